// ### lane_map_pkg.sv
// Constants shared by the lane mapper and its plan stage
`default_nettype none
package lane_map_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int LANES  = 8;   // most lanes of any mode
  localparam int CHANS  = 4;   // channels A..D
  localparam int SAMPS  = 8;   // samples per channel per frame, most
  localparam int SAMP_W = 9;   // converter resolution
  localparam int WORD_W = 40;  // five octets per lane per frame, most

  // ----------------------------------------
  // Link mode codes
  // ----------------------------------------
  localparam logic [3:0] LM_8B_LANE   = 4'h2;
  localparam logic [3:0] LM_9B_LANE   = 4'h3;
  localparam logic [3:0] LM_12B_PACK  = 4'h4;
  localparam logic [3:0] LM_8B_PAIR   = 4'h5;
  localparam logic [3:0] LM_12B_TRIO  = 4'h6;
  localparam logic [3:0] LM_8B_LANE66 = 4'h7;
  localparam logic [3:0] LM_12B_LANE  = 4'h8;
  localparam logic [3:0] LM_8B_SPLIT  = 4'h9;
  localparam logic [3:0] LM_9B_SPLIT  = 4'ha;

  // ----------------------------------------
  // Part variants and reset values
  // ----------------------------------------
  localparam logic [1:0] PART_QUAD   = 2'h0;
  localparam logic [1:0] PART_DUAL   = 2'h1;
  localparam logic [1:0] PART_SINGLE = 2'h2;
  localparam logic [3:0] RST_MODE    = 4'h0;
  localparam logic [2:0] RST_NCH     = 3'h0;
  localparam logic [3:0] RST_LANES   = 4'h0;
  localparam logic [2:0] RST_OCTETS  = 3'h0;
  localparam logic [3:0] RST_SAMPS   = 4'h0;
endpackage
`default_nettype wire

// ### plan_if.sv
// Frame plan carried from the plan stage to the packer
`default_nettype none
interface plan_if;
  logic [3:0] mode;    // active link mode
  logic [2:0] n_ch;    // channels present on the part
  logic [3:0] lanes;   // active lane count
  logic [2:0] octets;  // octets per lane per frame
  logic [3:0] samps;   // samples per channel per frame
  logic       coding;  // 1: 64B/66B, 0: 8B/10B
  logic       ok;      // mode and part legal
  modport src (output mode, n_ch, lanes, octets, samps, coding, ok);
  modport dst (input  mode, n_ch, lanes, octets, samps, coding, ok);
endinterface
`default_nettype wire

// ### lane_plan.sv
// Registered frame plan derived from link mode and part variant
`default_nettype none
module lane_plan import lane_map_pkg::*; (
  input  wire logic       clk,       // core clock
  input  wire logic       rst,       // sync reset, high
  input  wire logic       ce,        // clock enable
  input  wire logic [3:0] mode_sel,  // requested link mode
  input  wire logic [1:0] part_sel,  // part variant
  plan_if.src             plan       // plan out
);
  logic [3:0] mode_q, mode_d, lanes_q, lanes_d, samps_q, samps_d;
  logic [2:0] nch_q, nch_d, oct_q, oct_d;
  logic       cod_q, cod_d, ok_q, ok_d;

  always_comb begin
    mode_d = mode_sel;
    ok_d   = 1'b1;
    cod_d  = 1'b0;
    case (part_sel)
      PART_QUAD:   nch_d = 3'h4;
      PART_DUAL:   nch_d = 3'h2;
      PART_SINGLE: nch_d = 3'h1;
      default: begin
        nch_d = 3'h0;
        ok_d  = 1'b0;
      end
    endcase
    lanes_d = {1'b0, nch_d};
    oct_d   = 3'h1;
    samps_d = 4'h1;
    case (mode_sel)
      LM_8B_LANE: ;
      LM_8B_LANE66: cod_d = 1'b1;
      LM_9B_LANE: begin
        oct_d   = 3'h5;
        samps_d = 4'h4;
      end
      LM_12B_PACK: begin
        cod_d   = 1'b1;
        oct_d   = 3'h2;
        lanes_d = (nch_d == 3'h4) ? 4'h3 : {1'b0, nch_d};
      end
      LM_8B_PAIR: begin
        cod_d   = 1'b1;
        oct_d   = 3'h2;
        lanes_d = (nch_d == 3'h4) ? 4'h2 : 4'h1;
      end
      LM_12B_TRIO: begin
        cod_d   = 1'b1;
        oct_d   = 3'h2;
        samps_d = 4'h2;
        lanes_d = (nch_d == 3'h4) ? 4'h6 : (nch_d == 3'h2) ? 4'h3 : 4'h2;
      end
      LM_12B_LANE: begin
        cod_d   = 1'b1;
        oct_d   = 3'h3;
        samps_d = 4'h2;
      end
      LM_8B_SPLIT: begin
        samps_d = 4'h2;
        lanes_d = {nch_d, 1'b0};
      end
      LM_9B_SPLIT: begin
        oct_d   = 3'h5;
        samps_d = 4'h8;
        lanes_d = {nch_d, 1'b0};
      end
      default: ok_d = 1'b0;
    endcase
    if (!ok_d) begin
      lanes_d = RST_LANES;
      oct_d   = RST_OCTETS;
      samps_d = RST_SAMPS;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q  <= RST_MODE;
      nch_q   <= RST_NCH;
      lanes_q <= RST_LANES;
      oct_q   <= RST_OCTETS;
      samps_q <= RST_SAMPS;
      cod_q   <= 1'b0;
      ok_q    <= 1'b0;
    end else if (ce) begin
      mode_q  <= mode_d;
      nch_q   <= nch_d;
      lanes_q <= lanes_d;
      oct_q   <= oct_d;
      samps_q <= samps_d;
      cod_q   <= cod_d;
      ok_q    <= ok_d;
    end
  end

  assign plan.mode   = mode_q;
  assign plan.n_ch   = nch_q;
  assign plan.lanes  = lanes_q;
  assign plan.octets = oct_q;
  assign plan.samps  = samps_q;
  assign plan.coding = cod_q;
  assign plan.ok     = ok_q;
endmodule // lane_plan
`default_nettype wire

// ### lane_mapper.sv
// Transport-layer packer: converter samples into lane octets per link mode
//
// Contract
// - Mode 2 gives each channel one 8B/10B lane carrying one 8-bit sample per octet.
// - Mode 3 gives each channel one lane where four 9-bit samples, each plus a zero bit, fill five octets.
// - Mode 4 packs zero-padded 12-bit units back to back over 3/2/1 lanes, split on nibbles.
// - Mode 5 puts A then B (zero on single) on lane 0 and C then D on lane 1 of a quad.
// - Mode 6 packs two samples of two channels as 12-bit units over each group of three lanes.
// - Mode 7 is the mode 2 layout coded as 64B/66B.
// - Mode 8 gives each channel one lane where two 12-bit units fill three octets.
// - Mode 9 uses two lanes per channel, even samples low lane, odd samples high lane, 8 bits each.
// - Mode 10 uses two lanes per channel, even and odd samples, four padded samples in five octets.
// - Lanes of B need a dual or quad part, lanes of C and D a quad, numbered from lane zero.
`default_nettype none
module lane_mapper import lane_map_pkg::*; #(
  parameter int NUM_LANES = LANES,   // lane outputs
  parameter int NUM_CHANS = CHANS,   // channel inputs
  parameter int DEPTH     = SAMPS,   // samples per channel slot
  parameter int SAMP_W_P  = SAMP_W   // sample width
) (
  input  wire logic                              CLOCK,             // 200 MHz core clock
  input  wire logic                              RESET,             // sync reset, high
  input  wire logic                              CLOCK_ENABLE,      // freezes all state when low
  input  wire logic [3:0]                        LINK_MODE_SELECT,  // link mode
  input  wire logic [1:0]                        PART_SELECT,       // quad, dual or single
  input  wire logic                              SAMPLE_VALID,      // frame of samples present
  input  wire logic [NUM_CHANS*DEPTH*SAMP_W_P-1:0] SAMPLES,         // ch c sample k at (c*DEPTH+k)*9
  output logic                                   LANE_VALID,        // packed frame pulse
  output logic [NUM_LANES*WORD_W-1:0]            LANE_DATA,         // lane l at l*40, octet 0 on top
  output logic [NUM_LANES-1:0]                   LANE_ACTIVE,       // active lane mask
  output logic [3:0]                             LANE_COUNT,        // active lanes
  output logic [2:0]                             LANE_OCTETS,       // octets per lane per frame
  output logic [3:0]                             SAMPLES_USED,      // samples per channel per frame
  output logic                                   CODING_64B66B,     // line coding of all lanes
  output logic                                   MODE_ERROR         // mode or part not supported
);
  // ----------------------------------------
  // Plan stage
  // ----------------------------------------
  plan_if plan ();

  lane_plan u_plan (
    .clk      (CLOCK),
    .rst      (RESET),
    .ce       (CLOCK_ENABLE),
    .mode_sel (LINK_MODE_SELECT),
    .part_sel (PART_SELECT),
    .plan     (plan.src)
  );

  // ----------------------------------------
  // Channel masking
  // ----------------------------------------
  logic [SAMP_W_P-1:0] s [NUM_CHANS][DEPTH];

  always_comb begin
    for (int c = 0; c < NUM_CHANS; c++) begin
      for (int k = 0; k < DEPTH; k++) begin
        s[c][k] = (c < int'(plan.n_ch)) ? SAMPLES[(c*DEPTH+k)*SAMP_W_P +: SAMP_W_P] : '0;
      end
    end
  end

  // ----------------------------------------
  // Per-lane packing
  // ----------------------------------------
  logic [WORD_W-1:0] lane_w [NUM_LANES];

  for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
    localparam int CH = l % 4;
    localparam int HC = (l / 2) % 4;
    localparam int PH = l % 2;
    localparam int TP = (l / 3) % 2;
    localparam int TI = l % 3;
    always_comb begin
      logic [47:0] st;
      st = '0;
      case (plan.mode)
        LM_8B_LANE, LM_8B_LANE66: lane_w[l] = {s[CH][0][8:1], 32'h0};
        LM_9B_LANE: lane_w[l] = {s[CH][0], 1'b0, s[CH][1], 1'b0, s[CH][2], 1'b0, s[CH][3], 1'b0};
        LM_12B_PACK: begin
          st = {s[0][0], 3'h0, s[1][0], 3'h0, s[2][0], 3'h0, s[3][0], 3'h0};
          lane_w[l] = {st[47-16*TI -: 16], 24'h0};
        end
        LM_8B_PAIR: lane_w[l] = {s[2*PH][0][8:1], s[2*PH+1][0][8:1], 24'h0};
        LM_12B_TRIO: begin
          st = {s[2*TP][0], 3'h0, s[2*TP][1], 3'h0, s[2*TP+1][0], 3'h0, s[2*TP+1][1], 3'h0};
          lane_w[l] = {st[47-16*TI -: 16], 24'h0};
        end
        LM_12B_LANE: lane_w[l] = {s[CH][0], 3'h0, s[CH][1], 3'h0, 16'h0};
        // even low lane, odd high lane
        LM_8B_SPLIT: lane_w[l] = {s[HC][PH][8:1], 32'h0};
        LM_9B_SPLIT: lane_w[l] = {s[HC][PH], 1'b0, s[HC][PH+2], 1'b0,
                                  s[HC][PH+4], 1'b0, s[HC][PH+6], 1'b0};
        default: lane_w[l] = '0;
      endcase
      // lanes past the count stay quiet
      if (4'(l) >= plan.lanes) begin
        lane_w[l] = '0;
      end
    end

    quiet_lane_a: assert property (@(posedge CLOCK) disable iff (RESET)
      LANE_VALID && !LANE_ACTIVE[l] |-> LANE_DATA[l*WORD_W +: WORD_W] == '0)
      else $error("inactive lane not zero");
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  logic [NUM_LANES*WORD_W-1:0] data_q, data_d;
  logic [NUM_LANES-1:0]        act_q, act_d;
  logic [3:0]                  cnt_q, cnt_d, sam_q, sam_d;
  logic [2:0]                  oct_q, oct_d;
  logic                        val_q, val_d, cod_q, cod_d, err_q, err_d, live_q, live_d;

  // Samples held while no frame arrives, so lanes never show a torn frame
  always_comb begin
    val_d  = SAMPLE_VALID && plan.ok;
    data_d = data_q;
    act_d  = '0;
    cnt_d  = plan.lanes;
    oct_d  = plan.octets;
    sam_d  = plan.samps;
    cod_d  = plan.coding;
    // Plan flops hold reset values one edge after release, no false error then
    live_d = 1'b1;
    err_d  = live_q && !plan.ok;
    for (int l = 0; l < NUM_LANES; l++) begin
      act_d[l] = (l < int'(plan.lanes));
      if (val_d) begin
        data_d[l*WORD_W +: WORD_W] = lane_w[l];
      end
    end
  end

  // lane count, octets and coding exposed for the receiver setup
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      data_q <= '0;
      act_q  <= '0;
      cnt_q  <= RST_LANES;
      oct_q  <= RST_OCTETS;
      sam_q  <= RST_SAMPS;
      val_q  <= 1'b0;
      cod_q  <= 1'b0;
      err_q  <= 1'b0;
      live_q <= 1'b0;
    end else if (CLOCK_ENABLE) begin
      data_q <= data_d;
      act_q  <= act_d;
      cnt_q  <= cnt_d;
      oct_q  <= oct_d;
      sam_q  <= sam_d;
      val_q  <= val_d;
      cod_q  <= cod_d;
      err_q  <= err_d;
      live_q <= live_d;
    end
  end

  assign LANE_VALID    = val_q;
  assign LANE_DATA     = data_q;
  assign LANE_ACTIVE   = act_q;
  assign LANE_COUNT    = cnt_q;
  assign LANE_OCTETS   = oct_q;
  assign SAMPLES_USED  = sam_q;
  assign CODING_64B66B = cod_q;
  assign MODE_ERROR    = err_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [8:0]  a0, a1, a2, b0, c0, d0, d1;
  logic [39:0] l0, l1;
  assign a0 = SAMPLES[8:0];
  assign a1 = SAMPLES[17:9];
  assign a2 = SAMPLES[26:18];
  assign b0 = SAMPLES[DEPTH*SAMP_W_P +: 9];
  assign c0 = SAMPLES[2*DEPTH*SAMP_W_P +: 9];
  assign d0 = SAMPLES[3*DEPTH*SAMP_W_P +: 9];
  assign d1 = SAMPLES[(3*DEPTH+1)*SAMP_W_P +: 9];
  assign l0 = data_q[39:0];
  assign l1 = data_q[79:40];

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  sequence take(logic [3:0] m);
    CLOCK_ENABLE && SAMPLE_VALID && plan.ok && plan.mode == m;
  endsequence

  // Edges on which no new frame may enter the output flops
  sequence idle_edge;
    CLOCK_ENABLE && !SAMPLE_VALID;
  endsequence

  sequence frozen_edge;
    !CLOCK_ENABLE;
  endsequence

  mode2_octet_a: assert property (
    take(LM_8B_LANE) |=> LANE_VALID && !CODING_64B66B && LANE_OCTETS == 3'h1
      && l0[39:32] == 8'($past(a0) >> 1))
    else $error("mode 2 lane 0 octet wrong");

  mode3_pack_a: assert property (
    take(LM_9B_LANE) |=> LANE_OCTETS == 3'h5 && l0[39:20] == {$past(a0), 1'b0, $past(a1), 1'b0})
    else $error("mode 3 packing wrong");

  mode4_split_a: assert property (
    take(LM_12B_PACK) |=> CODING_64B66B && l0[39:28] == {$past(a0), 3'h0}
      && (plan.n_ch == 3'h1 || l0[27:24] == 4'($past(b0) >> 5)))
    else $error("mode 4 unit split wrong");

  mode4_zero_a: assert property (
    take(LM_12B_PACK) and (plan.n_ch == 3'h1) |=> l0[27:24] == 4'h0 && LANE_COUNT == 4'h1)
    else $error("mode 4 absent channel not zero");

  mode5_pair_a: assert property (
    take(LM_8B_PAIR) |=> l0[39:32] == 8'($past(a0) >> 1)
      && l0[31:24] == ((plan.n_ch == 3'h1) ? 8'h00 : 8'($past(b0) >> 1)))
    else $error("mode 5 octet pair wrong");

  mode6_units_a: assert property (
    take(LM_12B_TRIO) |=> l0[39:24] == {$past(a0), 3'h0, 4'($past(a1) >> 5)} && LANE_COUNT >= 4'h2)
    else $error("mode 6 unit straddle wrong");

  mode7_coding_a: assert property (
    take(LM_8B_LANE66) |=> CODING_64B66B && LANE_OCTETS == 3'h1 && l0[39:32] == 8'($past(a0) >> 1))
    else $error("mode 7 layout or coding wrong");

  mode8_pair_a: assert property (
    take(LM_12B_LANE) |=> LANE_OCTETS == 3'h3 && l0[39:16] == {$past(a0), 3'h0, $past(a1), 3'h0})
    else $error("mode 8 packing wrong");

  mode9_split_a: assert property (
    take(LM_8B_SPLIT) |=> l0[39:32] == 8'($past(a0) >> 1) && l1[39:32] == 8'($past(a1) >> 1))
    else $error("mode 9 even odd split wrong");

  mode10_split_a: assert property (
    take(LM_9B_SPLIT) |=> l0[39:20] == {$past(a0), 1'b0, $past(a2), 1'b0} && l1[39:30] == {$past(a1), 1'b0})
    else $error("mode 10 even odd split wrong");

  lane_mask_a: assert property (
    LANE_VALID |-> LANE_ACTIVE == 8'((16'h1 << LANE_COUNT) - 16'h1))
    else $error("active lanes not contiguous");

  lane_quiet_a: assert property (
    LANE_VALID && !LANE_ACTIVE[7] |-> data_q[319:280] == 40'h0)
    else $error("inactive lane carries data");

  mode4_lane2_a: assert property (
    take(LM_12B_PACK) and (plan.n_ch == 3'h4) |=> data_q[119:104] == {1'($past(c0)), 3'h0, $past(d0), 3'h0})
    else $error("mode 4 third lane wrong");

  mode5_lane1_a: assert property (
    take(LM_8B_PAIR) and (plan.n_ch == 3'h4) |=> l1[39:24] == {8'($past(c0) >> 1), 8'($past(d0) >> 1)})
    else $error("mode 5 second lane wrong");

  mode6_lane1_a: assert property (
    take(LM_12B_TRIO) |=> l1[39:24] == {5'($past(a1)), 3'h0,
      ((plan.n_ch == 3'h1) ? 8'h00 : 8'($past(b0) >> 1))})
    else $error("mode 6 second lane wrong");

  mode9_top_a: assert property (
    take(LM_8B_SPLIT) and (plan.n_ch == 3'h4) |=> data_q[319:312] == 8'($past(d1) >> 1))
    else $error("mode 9 top lane wrong");

  part_lanes_a: assert property (
    LANE_VALID |-> LANE_COUNT <= {$past(plan.n_ch), 1'b0})
    else $error("more lanes than the part owns");

  drop_illegal_a: assert property (
    CLOCK_ENABLE && !plan.ok |=> !LANE_VALID)
    else $error("frame passed under illegal setup");

  err_after_reset_a: assert property (
    $fell(RESET) |=> !MODE_ERROR)
    else $error("error flag raised by reset");

  pulse_single_a: assert property (
    idle_edge |=> !LANE_VALID)
    else $error("frame pulse without a frame");

  data_hold_a: assert property (
    idle_edge |=> $stable(LANE_DATA))
    else $error("lane data moved between frames");

  freeze_all_a: assert property (
    frozen_edge |=> $stable(LANE_VALID) && $stable(LANE_DATA) && $stable(LANE_COUNT) && $stable(MODE_ERROR))
    else $error("state moved while disabled");
endmodule // lane_mapper
`default_nettype wire

// ### lane_receiver.sv
// Receiver-side model that takes packed frames under its own configured layout
`default_nettype none
module lane_receiver import lane_map_pkg::*; (
  input  wire logic                    clk,          // core clock
  input  wire logic                    rst,          // sync reset, high
  input  wire logic                    lane_valid,   // frame pulse from packer
  input  wire logic [LANES*WORD_W-1:0] lane_data,    // packed lanes
  input  wire logic [3:0]              lane_count,   // packer lane count
  input  wire logic [2:0]              lane_octets,  // packer octets per lane
  input  wire logic                    coding,       // packer line coding
  input  wire logic [3:0]              rx_lanes,     // receiver lane setting
  input  wire logic [2:0]              rx_octets,    // receiver octet setting
  input  wire logic                    rx_coding,    // receiver coding setting
  output logic      [LANES*WORD_W-1:0] rx_data,      // last frame taken
  output var int                       rx_frames,    // frames taken
  output logic                         layout_ok     // layouts agreed on last frame
);
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_data   <= '0;
      rx_frames <= 0;
      layout_ok <= 1'b0;
    end else if (lane_valid) begin
      rx_data   <= lane_data;
      rx_frames <= rx_frames + 1;
      layout_ok <= lane_count == rx_lanes && lane_octets == rx_octets && coding == rx_coding;
    end
  end
endmodule // lane_receiver
`default_nettype wire

// ### transport_lane_mapper_tb_top.sv
// Self-checking bench for the transport lane mapper
`default_nettype none
module transport_lane_mapper_tb_top import lane_map_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(G, E, M) begin check_count++; if ((G) !== (E)) begin bad_count++; $display("wrong value at %0t: %s", $time, M); end end
  logic clock = 1'b0, reset = 1'b1, enable = 1'b1, svalid = 1'b0, lvalid, coding, merr, rx_ok, rx_coding = 1'b0;
  logic [3:0] mode = LM_8B_LANE, lcnt, sused, rx_lanes = '0;
  logic [1:0] part = PART_QUAD;
  logic [2:0] loct, rx_octets = '0;
  logic [287:0] smp = '0;
  logic [319:0] ldata, rx_data;
  logic [7:0] lact;
  int bad_count = 0, check_count = 0, rx_frames;
  always #2.5 clock = ~clock;
  lane_mapper dut_u (.CLOCK(clock), .RESET(reset), .CLOCK_ENABLE(enable), .LINK_MODE_SELECT(mode),
    .PART_SELECT(part), .SAMPLE_VALID(svalid), .SAMPLES(smp), .LANE_VALID(lvalid), .LANE_DATA(ldata),
    .LANE_ACTIVE(lact), .LANE_COUNT(lcnt), .LANE_OCTETS(loct), .SAMPLES_USED(sused),
    .CODING_64B66B(coding), .MODE_ERROR(merr));
  lane_receiver rx_u (.clk(clock), .rst(reset), .lane_valid(lvalid), .lane_data(ldata), .lane_count(lcnt),
    .lane_octets(loct), .coding(coding), .rx_lanes(rx_lanes), .rx_octets(rx_octets), .rx_coding(rx_coding),
    .rx_data(rx_data), .rx_frames(rx_frames), .layout_ok(rx_ok));
  // ----------------------------------------
  // Reference layout
  // ----------------------------------------
  function automatic logic [287:0] pat(input int sd);
    logic [287:0] v;
    for (int i = 0; i < 32; i++) v[i*9 +: 9] = 9'(i * 37 + sd * 101 + 346);
    return v;
  endfunction
  function automatic logic [319:0] exp_frame(input logic [3:0] m, input logic [1:0] p, input logic [287:0] v,
      output int ln, output logic [2:0] oc, output logic [3:0] su, output logic cd);
    logic [8:0] s [4][8];
    logic [47:0] u;
    logic [39:0] w [8];
    logic [319:0] r;
    int n, c, j;
    n = p == PART_QUAD ? 4 : p == PART_DUAL ? 2 : 1;
    for (int a = 0; a < 32; a++) s[a/8][a%8] = (a / 8 < n) ? v[a*9 +: 9] : 9'h000;
    for (int l = 0; l < 8; l++) w[l] = '0;
    cd = m >= LM_12B_PACK && m <= LM_12B_LANE;
    ln = n;
    case (m)
      LM_8B_LANE, LM_8B_LANE66: begin
        oc = 3'h1; su = 4'h1;
        for (int l = 0; l < n; l++) w[l] = {s[l][0][8:1], 32'h0};
      end
      LM_9B_LANE: begin
        oc = 3'h5; su = 4'h4;
        for (int l = 0; l < n; l++) w[l] = {s[l][0], 1'b0, s[l][1], 1'b0, s[l][2], 1'b0, s[l][3], 1'b0};
      end
      LM_12B_PACK: begin
        oc = 3'h2; su = 4'h1; ln = n == 4 ? 3 : n;
        u = {s[0][0], 3'h0, s[1][0], 3'h0, s[2][0], 3'h0, s[3][0], 3'h0};
        for (int l = 0; l < ln; l++) w[l] = {u[47-16*l -: 16], 24'h0};
      end
      LM_8B_PAIR: begin
        oc = 3'h2; su = 4'h1; ln = n == 4 ? 2 : 1;
        for (int l = 0; l < ln; l++) w[l] = {s[2*l][0][8:1], s[2*l+1][0][8:1], 24'h0};
      end
      LM_12B_TRIO: begin
        oc = 3'h2; su = 4'h2; ln = n == 4 ? 6 : n == 2 ? 3 : 2;
        for (c = 0; c < 2; c++) begin
          u = {s[2*c][0], 3'h0, s[2*c][1], 3'h0, s[2*c+1][0], 3'h0, s[2*c+1][1], 3'h0};
          for (int l = 0; l < 3; l++) if (3 * c + l < ln) w[3*c+l] = {u[47-16*l -: 16], 24'h0};
        end
      end
      LM_12B_LANE: begin
        oc = 3'h3; su = 4'h2;
        for (int l = 0; l < n; l++) w[l] = {s[l][0], 3'h0, s[l][1], 3'h0, 16'h0};
      end
      LM_8B_SPLIT: begin
        oc = 3'h1; su = 4'h2; ln = 2 * n;
        for (int l = 0; l < ln; l++) w[l] = {s[l/2][l%2][8:1], 32'h0};
      end
      default: begin
        oc = 3'h5; su = 4'h8; ln = 2 * n;
        for (int l = 0; l < ln; l++) begin
          c = l / 2;
          j = l % 2;
          w[l] = {s[c][j], 1'b0, s[c][j+2], 1'b0, s[c][j+4], 1'b0, s[c][j+6], 1'b0};
        end
      end
    endcase
    for (int l = 0; l < 8; l++) r[l*40 +: 40] = w[l];
    return r;
  endfunction
  // ----------------------------------------
  // Shared drivers, entered at a falling edge
  // ----------------------------------------
  task automatic run_frame(input logic [3:0] m, input logic [1:0] p, input logic [287:0] v);
    logic [319:0] e;
    int ln;
    logic [2:0] oc;
    logic [3:0] su;
    logic cd;
    e = exp_frame(m, p, v, ln, oc, su, cd);
    mode = m; part = p; rx_lanes = 4'(ln); rx_octets = oc; rx_coding = cd;
    @(negedge clock);
    smp = v; svalid = 1'b1;
    @(negedge clock);
    svalid = 1'b0;
    `CHK(lvalid, 1'b1, "no frame pulse")
    `CHK(ldata, e, "lane data")
    `CHK(lact, 8'((1 << ln) - 1), "active mask")
    `CHK(lcnt, 4'(ln), "lane count")
    `CHK({loct, sused, coding, merr}, {oc, su, cd, 1'b0}, "frame shape")
    @(negedge clock);
    `CHK({lvalid, ldata}, {1'b0, e}, "pulse not single or data not held")
    `CHK({rx_ok, rx_data}, {1'b1, e}, "receiver view")
  endtask
  task automatic all_parts(input logic [3:0] m, input int sd);
    run_frame(m, PART_QUAD, pat(sd));
    run_frame(m, PART_DUAL, pat(sd + 1));
    run_frame(m, PART_SINGLE, pat(sd + 2));
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_modes();
    all_parts(LM_8B_LANE, 1);
    all_parts(LM_9B_LANE, 2);
    all_parts(LM_12B_PACK, 3);
    run_frame(LM_12B_PACK, PART_DUAL, '1);
    run_frame(LM_12B_PACK, PART_SINGLE, '1);
    all_parts(LM_8B_PAIR, 4);
    all_parts(LM_12B_TRIO, 5);
    all_parts(LM_8B_LANE66, 6);
    all_parts(LM_12B_LANE, 7);
    all_parts(LM_8B_SPLIT, 8);
    all_parts(LM_9B_SPLIT, 9);
    $display("modes test done");
  endtask
  task automatic t_back();
    int f0, ln;
    logic [2:0] oc;
    logic [3:0] su;
    logic cd;
    run_frame(LM_9B_SPLIT, PART_QUAD, '1);
    f0 = rx_frames;
    smp = '0; svalid = 1'b1;
    @(negedge clock);
    smp = '1;
    `CHK(ldata, exp_frame(LM_9B_SPLIT, PART_QUAD, '0, ln, oc, su, cd), "first of pair")
    @(negedge clock);
    svalid = 1'b0;
    `CHK({lvalid, ldata}, {1'b1, exp_frame(LM_9B_SPLIT, PART_QUAD, '1, ln, oc, su, cd)}, "second of pair")
    @(negedge clock);
    `CHK(rx_frames, f0 + 2, "frames taken")
    $display("back to back test done");
  endtask
  task automatic t_enable();
    logic [319:0] e;
    int ln;
    logic [2:0] oc;
    logic [3:0] su;
    logic cd;
    run_frame(LM_8B_LANE, PART_QUAD, pat(20));
    e = exp_frame(LM_8B_LANE, PART_QUAD, pat(21), ln, oc, su, cd);
    enable = 1'b0; smp = pat(21); svalid = 1'b1;
    repeat (2) @(negedge clock);
    `CHK({lvalid, ldata}, {1'b0, exp_frame(LM_8B_LANE, PART_QUAD, pat(20), ln, oc, su, cd)}, "frozen")
    enable = 1'b1;
    @(negedge clock);
    svalid = 1'b0;
    `CHK({lvalid, ldata}, {1'b1, e}, "after thaw")
    $display("enable test done");
  endtask
  task automatic t_errors();
    logic [5:0] bad [5] = '{{4'h0, PART_QUAD}, {4'h1, PART_QUAD}, {4'hb, PART_DUAL}, {4'hf, PART_SINGLE}, {4'h2, 2'h3}};
    foreach (bad[i]) begin
      {mode, part} = bad[i];
      @(negedge clock);
      svalid = 1'b1;
      @(negedge clock);
      `CHK(merr, 1'b1, "illegal setup not flagged")
      @(negedge clock);
      svalid = 1'b0;
      `CHK({lvalid, merr}, 2'b01, "illegal frame passed")
    end
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    `CHK({lvalid, ldata, lact, lcnt, merr}, '0, "outputs after reset")
    run_frame(LM_12B_TRIO, PART_QUAD, pat(30));
    $display("error test done");
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    $display("wrong value at %0t: %s", $time, "run did not end");
    finish_test();
  end
  initial begin
    repeat (4) @(negedge clock);
    reset = 1'b0;
    t_modes();
    t_back();
    t_enable();
    t_errors();
    finish_test();
  end
endmodule // transport_lane_mapper_tb_top
`default_nettype wire
